// ==== src/aicm_filter.sv ====
// First-order smoothing filter stepped by a slow tick.
`timescale 1ns/1ps
module aicm_filter (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             tick,
  input  aicm_pkg::aicm_volt_t  x,
  input  wire logic [10:0]      tconst,
  output aicm_pkg::aicm_volt_t  y
);
  typedef struct packed {
    logic signed [aicm_pkg::VW+aicm_pkg::FRAC:0] acc;
  } aicm_filt_state_t;

  aicm_filt_state_t s;
  aicm_filt_state_t next_s;
  logic [3:0]       sh;
  logic signed [aicm_pkg::VW+aicm_pkg::FRAC:0] diff;

  // ==========================================================================
  // Step toward the input by 1/2^msb(tconst) per tick
  // ==========================================================================
  // A shift replaces a divider; the time constant is a power of two of ticks.
  always_comb begin
    next_s = s;
    sh = 4'h0;
    for (int i = 0; i < 11; i++) begin
      if (tconst[i]) sh = 4'(i);
    end
    diff = $signed({1'b0, x, {aicm_pkg::FRAC{1'b0}}}) - s.acc;
    if (tick) begin
      if (tconst == 11'h000) next_s.acc = $signed({1'b0, x, {aicm_pkg::FRAC{1'b0}}});
      else next_s.acc = s.acc + (diff >>> sh);
    end
  end

  // Filter state.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) s <= '0;
    else s <= next_s;
  end

  assign y = s.acc[aicm_pkg::VW+aicm_pkg::FRAC-1:aicm_pkg::FRAC];

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_filter_pass;
    tick && tconst == 11'h000 |=> y == $past(x);
  endproperty
  a_filter_pass: assert property (p_filter_pass) else $error("Zero filter time did not pass input");

endmodule : aicm_filter

// ==== src/aicm_map.sv ====
// Curve mapping, clamping, below-minimum option and snap for one channel.
`timescale 1ns/1ps
module aicm_map (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  aicm_pkg::aicm_volt_t    v,
  input  aicm_pkg::aicm_curve_t   crv,
  input  wire logic               four,
  input  wire logic               opt,
  input  aicm_pkg::aicm_pct_t     snap_pt,
  input  wire logic [10:0]        snap_band,
  output aicm_pkg::aicm_pct_t     setting
);
  typedef struct packed {
    aicm_pkg::aicm_pct_t raw;
    aicm_pkg::aicm_pct_t set;
  } aicm_map_state_t;

  aicm_map_state_t s;
  aicm_map_state_t next_s;
  logic [1:0]          a;
  logic [1:0]          b;
  logic signed [11:0]  dx;
  logic signed [11:0]  dy;
  logic signed [11:0]  dv;
  logic signed [23:0]  q;
  logic signed [11:0]  d;

  // ==========================================================================
  // Interpolate, then snap
  // ==========================================================================
  always_comb begin
    next_s = s;
    a = 2'h0;
    b = 2'h3;
    if (four && v >= crv.x[2]) a = 2'h2;
    else if (four && v >= crv.x[1]) begin
      a = 2'h1;
      b = 2'h2;
    end else if (four) b = 2'h1;
    dx = $signed({1'b0, crv.x[b]}) - $signed({1'b0, crv.x[a]});
    dy = $signed({crv.y[b][10], crv.y[b]}) - $signed({crv.y[a][10], crv.y[a]});
    dv = $signed({1'b0, v}) - $signed({1'b0, crv.x[a]});
    // Signed division truncates toward zero.
    q = (dx == 12'sh000) ? 24'sh000000 : (dy * dv) / dx;
    if (v >= crv.x[3]) next_s.raw = crv.y[3];
    else if (v < crv.x[0]) next_s.raw = opt ? 11'sh000 : crv.y[0];
    else next_s.raw = crv.y[a] + q[10:0];
    d = $signed({next_s.raw[10], next_s.raw}) - $signed({snap_pt[10], snap_pt});
    // Band is inclusive on both sides and checked after the curve.
    if (d <= $signed({1'b0, snap_band}) && d >= -$signed({1'b0, snap_band})) next_s.set = snap_pt;
    else next_s.set = next_s.raw;
  end

  // Mapper state.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) s <= '0;
    else s <= next_s;
  end

  assign setting = s.set;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_clamp_max;
    v >= crv.x[3] |=> s.raw == $past(crv.y[3]);
  endproperty
  a_clamp_max: assert property (p_clamp_max) else $error("Input above maximum not clamped");

  property p_below_min;
    v < crv.x[0] && v < crv.x[3] |=> s.raw == ($past(opt) ? 11'sh000 : $past(crv.y[0]));
  endproperty
  a_below_min: assert property (p_below_min) else $error("Below-minimum option ignored");

  // The stored result was formed with last cycle's point and band, so compare against those.
  property p_snap;
    12'(s.raw) - 12'($past(snap_pt)) <= $signed(12'($past(snap_band)))
      && 12'(s.raw) - 12'($past(snap_pt)) >= -$signed(12'($past(snap_band))) |-> s.set == $past(snap_pt);
  endproperty
  a_snap: assert property (p_snap) else $error("Value inside band not snapped");

  property p_outside_band;
    s.set != $past(snap_pt) |-> s.set == s.raw;
  endproperty
  a_outside_band: assert property (p_outside_band) else $error("Value outside band altered");

  c_snapped: cover property (s.set == snap_pt && s.raw != snap_pt);
  c_clamped: cover property (v > crv.x[3]);

endmodule : aicm_map

// ==== src/aicm_pkg.sv ====
// Shared constants, types and helpers for the analog input curve mapper.
package aicm_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_HZ      = 50_000_000;
  localparam int TICK_MS     = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // ==========================================================================
  // Widths: volts in 0.01 V, settings in 0.1 %, filter time in 0.01 s
  // ==========================================================================
  localparam int VW  = 11;
  localparam int PW  = 11;
  localparam int SDW = 12;
  localparam int AW  = 10;
  localparam int FRAC = 10;

  // ==========================================================================
  // Limits and reset values
  // ==========================================================================
  localparam logic [VW-1:0] V_LIMIT    = 11'h3e8;
  localparam logic [10:0]   P_LIMIT    = 11'h3e8;
  localparam logic [9:0]    SEL_RESET  = 10'h141;
  localparam logic [9:0]    OPT_RESET  = 10'h000;
  localparam logic [10:0]   FILT_RESET = 11'h00a;
  localparam logic [10:0]   BAND_RESET = 11'h005;
  localparam logic [10:0]   SNAP_RESET = 11'h000;
  localparam int            NCH        = 3;
  localparam int            NCRV       = 5;
  localparam int            NTWO       = 3;

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [AW-1:0] REG_SEL  = 10'h000;
  localparam logic [AW-1:0] REG_OPT  = 10'h004;
  localparam logic [AW-1:0] REG_CUR  = 10'h008;
  localparam logic [AW-1:0] REG_FILT = 10'h010;
  localparam logic [AW-1:0] REG_SNAP = 10'h020;
  localparam logic [AW-1:0] REG_BAND = 10'h030;
  localparam logic [AW-1:0] REG_OUT  = 10'h040;
  localparam logic [AW-1:0] REG_CRV  = 10'h080;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef logic [VW-1:0]        aicm_volt_t;
  typedef logic signed [PW-1:0] aicm_pct_t;

  typedef struct packed {
    logic           valid;
    logic [1:0]     ch;
    logic [SDW-1:0] data;
  } aicm_sample_t;

  typedef struct packed {
    logic [3:0][VW-1:0] x;
    logic [3:0][PW-1:0] y;
  } aicm_curve_t;

  // Points 0 and 3 are minimum and maximum; 1 and 2 are the inflections.
  localparam aicm_curve_t CURVE_RESET = '{x: {11'h3e8, 11'h258, 11'h12c, 11'h000},
                                          y: {11'h3e8, 11'h258, 11'h12c, 11'h000}};

  // Decimal digit pos (0 units, 1 tens, 2 hundreds) of a setting.
  function automatic logic [3:0] dec_digit(input logic [9:0] v, input int pos);
    logic [9:0] q;
    q = v;
    for (int i = 0; i < 2; i++) begin
      if (i < pos) q = q / 10'h00a;
    end
    return 4'(q % 10'h00a);
  endfunction : dec_digit

endpackage : aicm_pkg

// ==== src/aicm_top.sv ====
// Analog input curve mapper: APB registers, sample capture, filters and mappers.
// Functional notes
// - Input above the curve maximum is mapped as the maximum input.
// - Below minimum gives minimum setting, or zero when channel option is one.
// - Current inputs count each milliampere as half a volt.
// - Two-point curves interpolate linearly; settings limited to plus/minus 100 percent.
// - Two-point curves reset to 0 V to 0 % and 10 V to 100 %.
// - Curves four and five use four points; inflections reset to 3 V/30 %, 6 V/60 %.
// - Curve select holds three digits 1..5 per channel; reset 321.
// - Below-minimum option holds three 0/1 digits per channel; reset 000.
// - Per-channel smoothing filter, time up to 10 s, reset 0.1 s.
// - A setting inside the band around the snap point becomes the snap point.
// - Each channel has its own snap point (reset 0) and band (0..100 %).
// - Two-point minimum input stays within zero and the maximum, maximum within 10 V.
`timescale 1ns/1ps
module aicm_top #(
  parameter int TICK_CYCLES = aicm_pkg::TICK_CYCLES
) (
  input  wire logic                               clk,
  input  wire logic                               reset_n,
  input  wire logic [aicm_pkg::AW-1:0]            paddr,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [31:0]                        pwdata,
  output logic [31:0]                             prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  aicm_pkg::aicm_sample_t                  smp,
  output aicm_pkg::aicm_pct_t [aicm_pkg::NCH-1:0] ch_setting
);
  typedef struct packed {
    logic [9:0]                                        sel;
    logic [9:0]                                        opt;
    logic [aicm_pkg::NCH-1:0]                          cur;
    logic [aicm_pkg::NCH-1:0][10:0]                    filt;
    logic [aicm_pkg::NCH-1:0][10:0]                    snap;
    logic [aicm_pkg::NCH-1:0][10:0]                    band;
    aicm_pkg::aicm_curve_t [aicm_pkg::NCRV-1:0]        crv;
    logic [aicm_pkg::NCH-1:0][aicm_pkg::VW-1:0]        volt;
    logic [31:0]                                       tcnt;
    logic                                              tick;
    logic                                              ack;
    logic                                              err;
    logic [31:0]                                       rdata;
  } aicm_state_t;

  localparam aicm_state_t STATE_RESET = '{
    sel:   aicm_pkg::SEL_RESET,
    opt:   aicm_pkg::OPT_RESET,
    cur:   '0,
    filt:  {aicm_pkg::NCH{aicm_pkg::FILT_RESET}},
    snap:  {aicm_pkg::NCH{aicm_pkg::SNAP_RESET}},
    band:  {aicm_pkg::NCH{aicm_pkg::BAND_RESET}},
    crv:   {aicm_pkg::NCRV{aicm_pkg::CURVE_RESET}},
    volt:  '0,
    tcnt:  '0,
    tick:  1'b0,
    ack:   1'b0,
    err:   1'b0,
    rdata: '0
  };

  aicm_state_t          s;
  aicm_state_t          next_s;
  logic                 bad;
  logic [31:0]          rd;
  logic [aicm_pkg::AW-1:0] coff;
  logic [2:0]           cidx;
  logic [1:0]           pidx;
  logic                 isy;
  logic                 crv_hit;
  logic [1:0]           ridx;
  logic                 idx_ok;
  logic signed [31:0]   sw;

  // Filtered volts, one word per channel, feed the mappers.
  aicm_pkg::aicm_volt_t [aicm_pkg::NCH-1:0] filtered;

  // ==========================================================================
  // Address decode and write checks
  // ==========================================================================
  // Writes that would break a documented range are refused with pslverr and
  // leave the register unchanged, so the stored set always stays legal.
  always_comb begin
    coff    = paddr - aicm_pkg::REG_CRV;
    cidx    = coff[7:5];
    pidx    = coff[4:3];
    isy     = coff[2];
    ridx    = paddr[3:2];
    idx_ok  = ridx < 2'(aicm_pkg::NCH);
    sw      = $signed(pwdata);

    // Curves one to three map only their end points.
    crv_hit = paddr >= aicm_pkg::REG_CRV && cidx < 3'(aicm_pkg::NCRV) && paddr[1:0] == 2'h0
              && (cidx >= 3'(aicm_pkg::NTWO) || pidx == 2'h0 || pidx == 2'h3);
    bad = 1'b0;
    rd  = 32'h0000_0000;

    // Misaligned and unmapped addresses are refused; curve addresses alias every 0x100 above the curve block.
    if (paddr[1:0] != 2'h0) bad = 1'b1;
    else if (paddr == aicm_pkg::REG_SEL) begin
      rd = {22'h0, s.sel};
      for (int i = 0; i < aicm_pkg::NCH; i++) begin
        if (aicm_pkg::dec_digit(pwdata[9:0], i) < 4'h1 || aicm_pkg::dec_digit(pwdata[9:0], i) > 4'h5)
          bad = pwrite;
      end
      if (pwdata > 32'h0000_03e7) bad = pwrite;
    end else if (paddr == aicm_pkg::REG_OPT) begin
      rd = {22'h0, s.opt};
      for (int i = 0; i < aicm_pkg::NCH; i++) begin
        if (aicm_pkg::dec_digit(pwdata[9:0], i) > 4'h1) bad = pwrite;
      end
      if (pwdata > 32'h0000_03e7) bad = pwrite;
    end else if (paddr == aicm_pkg::REG_CUR) begin
      rd = {29'h0, s.cur};
    end else if (paddr[9:4] == aicm_pkg::REG_FILT[9:4] && idx_ok) begin
      rd = {21'h0, s.filt[ridx]};
      if (pwdata > 32'(aicm_pkg::P_LIMIT)) bad = pwrite;
    end else if (paddr[9:4] == aicm_pkg::REG_SNAP[9:4] && idx_ok) begin
      rd = 32'($signed(s.snap[ridx]));
      if (sw > 32'sh3e8 || sw < -32'sh3e8) bad = pwrite;
    end else if (paddr[9:4] == aicm_pkg::REG_BAND[9:4] && idx_ok) begin
      rd = {21'h0, s.band[ridx]};
      if (pwdata > 32'(aicm_pkg::P_LIMIT)) bad = pwrite;
    end else if (paddr[9:4] == aicm_pkg::REG_OUT[9:4] && idx_ok) begin
      rd = 32'($signed(ch_setting[ridx]));
      bad = pwrite;
    end else if (crv_hit) begin
      if (isy) begin
        rd = 32'($signed(s.crv[cidx].y[pidx]));
        if (sw > 32'sh3e8 || sw < -32'sh3e8) bad = pwrite;
      end else begin
        rd = {21'h0, s.crv[cidx].x[pidx]};
        if (pwdata > 32'(aicm_pkg::V_LIMIT)) bad = pwrite;
        if (cidx < 3'(aicm_pkg::NTWO) && pidx == 2'h0 && pwdata > 32'(s.crv[cidx].x[3])) bad = pwrite;
        if (cidx < 3'(aicm_pkg::NTWO) && pidx == 2'h3 && pwdata < 32'(s.crv[cidx].x[0])) bad = pwrite;
      end
    end else bad = 1'b1;
  end

  // ==========================================================================
  // Next state: tick, samples, bus
  // ==========================================================================
  always_comb begin
    next_s = s;

    // Slow tick for the filters, one pulse every TICK_CYCLES clocks.
    next_s.tick = 1'b0;
    if (s.tcnt >= 32'(TICK_CYCLES - 1)) begin
      next_s.tcnt = '0;
      next_s.tick = 1'b1;
    end else next_s.tcnt = s.tcnt + 32'h1;
    // Latest sample per channel; current readings are halved into volts.
    if (smp.valid && smp.ch < 2'(aicm_pkg::NCH)) begin
      if (s.cur[smp.ch]) next_s.volt[smp.ch] = smp.data[11:1];
      else if (smp.data[11]) next_s.volt[smp.ch] = '1;
      else next_s.volt[smp.ch] = smp.data[10:0];
    end
    // One wait state so read data and the error flag leave flip-flops.
    next_s.ack = psel && penable && !s.ack;
    if (psel && penable && !s.ack) begin
      next_s.err   = bad;
      next_s.rdata = pwrite ? 32'h0000_0000 : rd;
    end

    // A write lands only at the edge where the master samples pready.
    if (psel && penable && s.ack && pwrite && !s.err) begin
      if (paddr == aicm_pkg::REG_SEL) next_s.sel = pwdata[9:0];
      else if (paddr == aicm_pkg::REG_OPT) next_s.opt = pwdata[9:0];
      else if (paddr == aicm_pkg::REG_CUR) next_s.cur = pwdata[2:0];
      else if (paddr[9:4] == aicm_pkg::REG_FILT[9:4]) next_s.filt[ridx] = pwdata[10:0];
      else if (paddr[9:4] == aicm_pkg::REG_SNAP[9:4]) next_s.snap[ridx] = pwdata[10:0];
      else if (paddr[9:4] == aicm_pkg::REG_BAND[9:4]) next_s.band[ridx] = pwdata[10:0];
      else if (isy) next_s.crv[cidx].y[pidx] = pwdata[10:0];
      else next_s.crv[cidx].x[pidx] = pwdata[10:0];
    end
  end

  // Block state.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) s <= STATE_RESET;
    else s <= next_s;
  end

  assign prdata  = s.rdata;
  assign pready  = s.ack;
  assign pslverr = s.ack & s.err;

  // ==========================================================================
  // Per-channel filter and curve mapper
  // ==========================================================================
  // Curve digit d picks curve d; digits four and five are four-point curves.
  for (genvar g = 0; g < aicm_pkg::NCH; g++) begin : g_ch
    logic [3:0] dig;
    assign dig = aicm_pkg::dec_digit(s.sel, g);

    // Smooth the latest volts before the curve sees them.
    aicm_filter u_filter (
      .clk     (clk),
      .reset_n (reset_n),
      .tick    (s.tick),
      .x       (s.volt[g]),
      .tconst  (s.filt[g]),
      .y       (filtered[g])
    );

    // The mapper registers its result one cycle after the filter.
    aicm_map u_map (
      .clk       (clk),
      .reset_n   (reset_n),
      .v         (filtered[g]),
      .crv       (s.crv[3'(dig - 4'h1)]),
      .four      (dig > 4'(aicm_pkg::NTWO)),
      .opt       (aicm_pkg::dec_digit(s.opt, g) == 4'h1),
      .snap_pt   (s.snap[g]),
      .snap_band (s.band[g]),
      .setting   (ch_setting[g])
    );
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_sel_digits;
    aicm_pkg::dec_digit(s.sel, 0) inside {[4'h1:4'h5]} && aicm_pkg::dec_digit(s.sel, 1) inside {[4'h1:4'h5]}
      && aicm_pkg::dec_digit(s.sel, 2) inside {[4'h1:4'h5]} && s.sel < 10'h3e8;
  endproperty
  a_sel_digits: assert property (p_sel_digits) else $error("Curve select digit out of range");

  property p_opt_digits;
    aicm_pkg::dec_digit(s.opt, 0) <= 4'h1 && aicm_pkg::dec_digit(s.opt, 1) <= 4'h1
      && aicm_pkg::dec_digit(s.opt, 2) <= 4'h1;
  endproperty
  a_opt_digits: assert property (p_opt_digits) else $error("Below-minimum option digit out of range");

  property p_two_point_order;
    s.crv[0].x[0] <= s.crv[0].x[3] && s.crv[1].x[0] <= s.crv[1].x[3] && s.crv[2].x[0] <= s.crv[2].x[3]
      && s.crv[0].x[3] <= aicm_pkg::V_LIMIT;
  endproperty
  a_two_point_order: assert property (p_two_point_order) else $error("Two-point curve inputs disordered");

  property p_current_half;
    smp.valid && smp.ch == 2'h0 && s.cur[0] |=> s.volt[0] == $past(smp.data[11:1]);
  endproperty
  a_current_half: assert property (p_current_half) else $error("Current sample not halved");

  property p_ready_one_cycle;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_ready_one_cycle: assert property (p_ready_one_cycle) else $error("Ready not a single cycle after wait");

  property p_refused_write;
    pready && pslverr && pwrite && paddr == aicm_pkg::REG_SEL |=> $stable(s.sel);
  endproperty
  a_refused_write: assert property (p_refused_write) else $error("Refused write changed select");

  // Writes carry no read data back.
  property p_write_reads_zero;
    pready && pwrite |-> prdata == 32'h0000_0000;
  endproperty
  a_write_reads_zero: assert property (p_write_reads_zero) else $error("Write returned read data");

  // Refused writes keep every stored field inside its legal range.
  property p_filter_range;
    s.filt[0] <= aicm_pkg::P_LIMIT && s.filt[1] <= aicm_pkg::P_LIMIT && s.filt[2] <= aicm_pkg::P_LIMIT;
  endproperty
  a_filter_range: assert property (p_filter_range) else $error("Filter time out of range");

  property p_band_range;
    s.band[0] <= aicm_pkg::P_LIMIT && s.band[1] <= aicm_pkg::P_LIMIT && s.band[2] <= aicm_pkg::P_LIMIT;
  endproperty
  a_band_range: assert property (p_band_range) else $error("Snap band out of range");

  property p_snap_range;
    $signed(s.snap[0]) >= -11'sh3e8 && $signed(s.snap[0]) <= 11'sh3e8
      && $signed(s.snap[1]) >= -11'sh3e8 && $signed(s.snap[1]) <= 11'sh3e8
      && $signed(s.snap[2]) >= -11'sh3e8 && $signed(s.snap[2]) <= 11'sh3e8;
  endproperty
  a_snap_range: assert property (p_snap_range) else $error("Snap point out of range");

  // An accepted write lands on the edge that ends the access.
  property p_select_write;
    pready && !pslverr && pwrite && paddr == aicm_pkg::REG_SEL |=> s.sel == $past(pwdata[9:0]);
  endproperty
  a_select_write: assert property (p_select_write) else $error("Accepted select write lost");

  property p_option_write;
    pready && !pslverr && pwrite && paddr == aicm_pkg::REG_OPT |=> s.opt == $past(pwdata[9:0]);
  endproperty
  a_option_write: assert property (p_option_write) else $error("Accepted option write lost");

  // Covers for the main scenarios.
  c_write_refused: cover property (pready && pslverr && pwrite);
  c_current_sample: cover property (smp.valid && s.cur != 3'h0);
  c_four_point: cover property (aicm_pkg::dec_digit(s.sel, 0) == 4'h5);

endmodule : aicm_top

// ==== verif/aicm_src.sv ====
// Analog source model: delivers converter samples to the mapper.
`timescale 1ns/1ps
module aicm_src (
  input  wire logic             clk,
  output aicm_pkg::aicm_sample_t smp
);
  logic        go;
  logic [1:0]  c;
  logic [11:0] dv;
  logic [11:0] junk;

  initial begin
    go   = 1'b0;
    c    = 2'h0;
    dv   = 12'h000;
    junk = 12'h000;
    smp  = '0;
  end

  // Idle cycles show a changing pattern on an ignored channel, so stale data never looks valid.
  always @(posedge clk) begin
    junk <= junk + 12'h5a5;
    if (go) begin
      smp <= '{valid: 1'b1, ch: c, data: dv};
      go  <= 1'b0;
    end else begin
      smp <= '{valid: 1'b0, ch: 2'h3, data: ~junk};
    end
  end

  // One sample strobe per call, in 0.01 V or 0.01 mA units.
  task automatic put(input logic [1:0] ch, input logic [11:0] d);
    @(posedge clk);
    go <= 1'b1;
    c  <= ch;
    dv <= d;
    @(posedge clk);
    @(posedge clk);
  endtask : put
endmodule : aicm_src

// ==== verif/analog_input_curve_mapper_bench.sv ====
// Self-checking bench for the analog input curve mapper.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fails++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module analog_input_curve_mapper_bench;
  logic                                   clk = 1'b0;
  logic                                   reset_n = 1'b0;
  logic [9:0]                             paddr = '0;
  logic                                   psel = 1'b0;
  logic                                   penable = 1'b0;
  logic                                   pwrite = 1'b0;
  logic [31:0]                            pwdata = '0;
  logic [31:0]                            prdata;
  logic                                   pready;
  logic                                   pslverr;
  aicm_pkg::aicm_sample_t                 smp;
  aicm_pkg::aicm_pct_t [aicm_pkg::NCH-1:0] ch_setting;
  int                                     fails = 0;
  int                                     comparisons = 0;

  // ==========================================================================
  // Clock, design and source
  // ==========================================================================
  always #10 clk = ~clk;

  aicm_top #(.TICK_CYCLES(4)) i_dut (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .smp(smp), .ch_setting(ch_setting));
  aicm_src i_src (.clk(clk), .smp(smp));

  // ==========================================================================
  // Bus and sample tasks
  // ==========================================================================
  // The request is held until pready is sampled high; only the bench timeout ends a stuck wait.
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    `CHK("pslverr", ee, e)
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [31:0] ex);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK("prdata", ex, r)
  endtask : rd

  // Curve register address: curve 1..5, point 0..3, output half when y is set.
  function automatic logic [9:0] ca(input int c, input int p, input int y);
    return 10'(128 + (c - 1) * 32 + p * 8 + y * 4);
  endfunction : ca

  // Sixteen cycles exceed the tick plus pipeline latency with a pass-through filter.
  task automatic feed(input logic [1:0] ch, input logic [11:0] d, input int ex);
    i_src.put(ch, d);
    repeat (16) @(posedge clk);
    `CHK("ch_setting", 11'(ex), ch_setting[ch])
  endtask : feed

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_defaults;
    rd(10'h000, 32'h141);
    rd(10'h004, 32'h0);
    rd(10'h018, 32'ha);
    rd(10'h024, 32'h0);
    rd(10'h034, 32'h5);
    rd(ca(2, 3, 0), 32'h3e8);
    rd(ca(3, 3, 1), 32'h3e8);
    rd(ca(1, 0, 1), 32'h0);
    rd(ca(4, 1, 0), 32'h12c);
    rd(ca(4, 1, 1), 32'h12c);
    rd(ca(5, 2, 1), 32'h258);
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_curves;
    for (int i = 0; i < 3; i++) wr(10'(16 + 4 * i), 32'h0, 1'b0);
    wr(10'h030, 32'h0, 1'b0);
    feed(2'd0, 12'd500, 500);
    feed(2'd0, 12'd1200, 1000);
    wr(ca(1, 0, 1), 32'hfffffc18, 1'b0);
    feed(2'd0, 12'd250, -500);
    wr(10'h000, 32'd325, 1'b0);
    wr(ca(5, 2, 1), 32'd900, 1'b0);
    feed(2'd0, 12'd450, 600);
    feed(2'd0, 12'd800, 950);
    $display("test curves done");
  endtask : t_curves

  task automatic t_refuse;
    wr(10'h000, 32'd326, 1'b1);
    rd(10'h000, 32'd325);
    wr(10'h004, 32'd2, 1'b1);
    wr(10'h010, 32'd1001, 1'b1);
    wr(ca(1, 3, 0), 32'd800, 1'b0);
    wr(ca(1, 0, 0), 32'd900, 1'b1);
    wr(ca(1, 0, 0), 32'd200, 1'b0);
    wr(ca(2, 1, 0), 32'd100, 1'b1);
    wr(10'h040, 32'd1, 1'b1);
    wr(ca(4, 0, 1), 32'd1001, 1'b1);
    $display("test refusals done");
  endtask : t_refuse

  task automatic t_below;
    wr(10'h000, 32'd321, 1'b0);
    feed(2'd0, 12'd100, -1000);
    feed(2'd0, 12'd350, -500);
    wr(10'h004, 32'd1, 1'b0);
    feed(2'd0, 12'd100, 0);
    wr(10'h008, 32'd1, 1'b0);
    feed(2'd0, 12'd1300, 500);
    $display("test below and current done");
  endtask : t_below

  task automatic t_snap;
    wr(10'h024, 32'd500, 1'b0);
    wr(10'h034, 32'd10, 1'b0);
    feed(2'd1, 12'd510, 500);
    feed(2'd1, 12'd490, 500);
    feed(2'd1, 12'd511, 511);
    rd(10'h044, 32'd511);
    wr(10'h024, 32'hfffffc17, 1'b1);
    wr(10'h034, 32'd1001, 1'b1);
    $display("test snap done");
  endtask : t_snap

  // A long filter time keeps a full-scale step far from its end value after a few ticks.
  task automatic t_filter;
    wr(10'h018, 32'd1000, 1'b0);
    i_src.put(2'd2, 12'd1000);
    repeat (16) @(posedge clk);
    `CHK("slow filter", 1'b1, ch_setting[2] < 11'sh064)
    $display("test filter done");
  endtask : t_filter

  // ==========================================================================
  // Run control
  // ==========================================================================
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // Reset is held for sixteen cycles, then the scenarios run in order.
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_defaults();
    t_curves();
    t_refuse();
    t_below();
    t_snap();
    t_filter();
    end_of_test();
  end

  // The whole run needs about four hundred cycles, so this limit only catches a hang.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule : analog_input_curve_mapper_bench
